// File: logic/csfl_flag_calc.sv
// Purpose: combinational flag evaluation for add, subtract and logic results
// Assumes: operands are raw, subtraction computes a minus b
// Notes:   carry reads as not-borrow on subtraction
`timescale 1ns/100ps
module csfl_flag_calc
    import csfl_pkg::*;
(
    // request and current carry
    input  wire csfl_req_s   req,
    input  wire logic        c_in,
    // evaluated flags and result
    output csfl_flags_s      flags,
    output logic [15:0]      result
);
    logic [15:0] b_eff;   // inverted operand on subtract
    logic        cin;     // carry into bit 0
    logic        is_sub;  // subtract family
    logic [16:0] sum;     // full sum with carry out
    logic [4:0]  nib;     // low nibble sum
    logic [8:0]  lob;     // low byte sum
    logic        msb_a;   // sign of a at width
    logic        msb_b;   // sign of b_eff at width
    logic        msb_r;   // sign of result at width

    // flag evaluation
    always_comb begin
        is_sub = (req.op == op_sub) || (req.op == op_subb);
        b_eff  = is_sub ? ~req.b : req.b;
        unique case (req.op)
            op_add:   cin = 1'b0;
            op_sub:   cin = 1'b1;
            op_addc,
            op_subb:  cin = c_in;
            default:  cin = 1'b0;
        endcase
        sum    = {1'b0, req.a} + {1'b0, b_eff} + {16'h0000, cin};
        nib    = {1'b0, req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        lob    = {1'b0, req.a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
        result = (req.op == op_logic) ? req.a : sum[15:0];
        msb_a  = req.byte_mode ? req.a[7] : req.a[15];
        msb_b  = req.byte_mode ? b_eff[7] : b_eff[15];
        msb_r  = req.byte_mode ? result[7] : result[15];
        flags.dc = req.byte_mode ? nib[4] : lob[8];
        flags.n  = msb_r;
        flags.ov = (msb_a == msb_b) && (msb_r != msb_a);
        flags.z  = req.byte_mode ? (result[7:0] == 8'h00) : (result == 16'h0000);
        flags.c  = req.byte_mode ? lob[8] : sum[16];
    end
endmodule

// File: logic/csfl_status.sv
// Purpose: cpu status word holding result flags, repeat status and priority bits
// Assumes: one 100 MHz clock, datapath requests are synchronous one-cycle strobes
// Notes:   hardware flag updates win over a software write in the same cycle
`timescale 1ns/100ps

// Function
// - half carry from bit 4 or 8
// - low priority bits binary, extension adds eight
// - repeat bit mirrors loop, not writable
// - negative flag follows result sign
// - overflow flag on signed sign wrap
// - nesting off locks low priority bits
// - full level is extension over low bits
// - carry and half carry act as inverted borrows (set when no borrow)
module csfl_status
    import csfl_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // datapath side
    input  wire csfl_req_s   flag_req,
    input  wire logic        repeat_busy,
    input  wire logic        prio_ext_set,
    // status outputs
    output logic [15:0]      cpu_status_word,
    output logic [3:0]       cpu_priority_level,
    output logic             nesting_off_bit,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    // whole block state
    typedef struct packed {
        logic        dc;       // half_carry_flag
        logic [2:0]  ipl;      // cpu_priority_low_bits
        logic        ra;       // repeat_active_bit
        logic        n;        // negative
        logic        ov;       // sign_wrap_flag
        logic        z;        // zero
        logic        c;        // carry
        logic        ext;      // priority_extension_bit
        logic        nest;     // nesting_off_bit
        logic        aw_got;   // write address held
        logic [3:0]  awaddr;   // held write address
        logic        w_got;    // write data held
        logic [31:0] wdata;    // held write data
        logic [3:0]  wstrb;    // held byte enables
        logic        bvalid;   // response pending
        logic [1:0]  bresp;    // response code
        logic        rvalid;   // read data pending
        logic [31:0] rdata;    // read data
        logic [1:0]  rresp;    // read code
    } csfl_state_s;

    csfl_state_s st;       // registered state
    csfl_state_s next_st;  // next state
    csfl_flags_s fl;       // evaluated flags
    logic [15:0] sw_new;   // merged software write to status
    logic [15:0] cw_new;   // merged write to core or config
    logic        wr_go;    // write performed this cycle
    logic [15:0] stat_now; // assembled status word

    // flag evaluator
    csfl_flag_calc u_calc (
        .req    (flag_req),
        .c_in   (st.c),
        .flags  (fl),
        .result ()
    );

    // assemble the status word, unused bits read zero
    always_comb begin
        stat_now                        = 16'h0000;
        stat_now[BIT_DC]                = st.dc;
        stat_now[BIT_IPL+2:BIT_IPL]     = st.ipl;
        stat_now[BIT_RA]                = st.ra;
        stat_now[BIT_N]                 = st.n;
        stat_now[BIT_OV]                = st.ov;
        stat_now[BIT_Z]                 = st.z;
        stat_now[BIT_C]                 = st.c;
    end

    // next state
    always_comb begin
        next_st = st;
        sw_new  = csfl_merge(stat_now, st.wdata, st.wstrb);
        cw_new  = csfl_merge(16'h0000, st.wdata, st.wstrb);
        wr_go   = st.aw_got && st.w_got && !st.bvalid;
        // address and data channels taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        // perform the write once both halves are held
        if (wr_go) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = RESP_OKAY;
            unique case (st.awaddr)
                OFS_STATUS: begin
                    next_st.dc = sw_new[BIT_DC];
                    next_st.n  = sw_new[BIT_N];
                    next_st.ov = sw_new[BIT_OV];
                    next_st.z  = sw_new[BIT_Z];
                    next_st.c  = sw_new[BIT_C];
                    if (!st.nest) begin
                        next_st.ipl = sw_new[BIT_IPL+2:BIT_IPL];
                    end
                end
                OFS_CORE: begin
                    // extension bit is clear only from software
                    if (st.wstrb[0] && !cw_new[BIT_EXT]) begin
                        next_st.ext = 1'b0;
                    end
                end
                OFS_CTRL: begin
                    // only the upper byte lane reaches the nesting bit
                    if (st.wstrb[1]) begin
                        next_st.nest = cw_new[BIT_NEST];
                    end
                end
                default: begin
                    next_st.bresp = RESP_DECERR;
                end
            endcase
        end
        // response leaves on bready
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // read capture
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_STATUS: next_st.rdata = {16'h0000, stat_now};
                OFS_CORE:   next_st.rdata = {28'h0000000, st.ext, 3'h0};
                OFS_CTRL:   next_st.rdata = {16'h0000, st.nest, 15'h0000};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = RESP_DECERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // datapath flag update wins over the software write
        if (flag_req.valid) begin
            next_st.n = fl.n;
            next_st.z = fl.z;
            if (flag_req.op != op_logic) begin
                next_st.dc = fl.dc;
                next_st.ov = fl.ov;
                next_st.c  = fl.c;
            end
        end
        // repeat bit tracks the loop only
        next_st.ra = repeat_busy;
        // hardware set wins over a clear
        if (prio_ext_set) begin
            next_st.ext = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st        <= '0;
            st.dc     <= RST_STATUS[BIT_DC];
            st.ipl    <= RST_STATUS[BIT_IPL+2:BIT_IPL];
            st.ext    <= RST_EXT;
            st.nest   <= RST_NEST;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign cpu_status_word    = stat_now;
    // binary level, plus eight when extended
    assign cpu_priority_level = {st.ext, st.ipl};
    assign nesting_off_bit    = st.nest;
    assign s_axi_awready      = !st.aw_got && !st.bvalid;
    assign s_axi_wready       = !st.w_got && !st.bvalid;
    assign s_axi_bvalid       = st.bvalid;
    assign s_axi_bresp        = st.bresp;
    assign s_axi_arready      = !st.rvalid;
    assign s_axi_rvalid       = st.rvalid;
    assign s_axi_rdata        = st.rdata;
    assign s_axi_rresp        = st.rresp;

    // helper sums for checks
    logic [8:0]  chk_lo;  // low byte add
    logic [15:0] chk_sum; // word add
    assign chk_lo  = {1'b0, flag_req.a[7:0]} + {1'b0, flag_req.b[7:0]};
    assign chk_sum = flag_req.a + flag_req.b;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_half_word: assert property (flag_req.valid && flag_req.op == op_add &&
        !flag_req.byte_mode |=> st.dc == $past(chk_lo[8]))
        else $error("half carry wrong on word add");
    a_level_form: assert property (prio_ext_set |=>
        cpu_priority_level == 4'h8 + {1'b0, cpu_status_word[7:5]})
        else $error("extended level not eight above low bits");
    a_ra_follow: assert property (repeat_busy ##1 repeat_busy |=> st.ra [*1])
        else $error("repeat bit not set during loop");
    a_neg_flag: assert property (flag_req.valid && flag_req.op == op_logic &&
        !flag_req.byte_mode |=> st.n == $past(flag_req.a[15]))
        else $error("negative flag wrong");
    a_ov_word: assert property (flag_req.valid && flag_req.op == op_add &&
        !flag_req.byte_mode && flag_req.a[15] == flag_req.b[15] &&
        chk_sum[15] != flag_req.a[15] |=> st.ov)
        else $error("overflow missed");
    a_ipl_locked: assert property (st.nest |=> st.ipl == $past(st.ipl))
        else $error("priority bits changed while locked");
    a_sub_borrow: assert property (flag_req.valid && flag_req.op == op_sub &&
        !flag_req.byte_mode && flag_req.a < flag_req.b |=> !st.c)
        else $error("borrow not shown on subtract");
    a_zero_flag: assert property (flag_req.valid && flag_req.op == op_logic &&
        flag_req.a == 16'h0000 |=> st.z && !st.n)
        else $error("zero flag wrong");
    a_write_resp: assert property (st.aw_got && st.w_got && !st.bvalid |=> s_axi_bvalid)
        else $error("write response late");

    c_sub_op: cover property (flag_req.valid && flag_req.op == op_subb);
    c_ipl_lock: cover property (st.nest && wr_go && st.awaddr == OFS_STATUS);
    c_repeat: cover property (st.ra ##1 !st.ra);
endmodule

// File: shared/csfl_pkg.sv
// Purpose: shared constants and types for the cpu status flag block
// Assumes: 32-bit axi4-lite register access, 16-bit status word
// Notes:   register offsets are byte addresses
package csfl_pkg;
    // register byte offsets
    localparam logic [3:0]  OFS_STATUS  = 4'h0;
    localparam logic [3:0]  OFS_CORE    = 4'h4;
    localparam logic [3:0]  OFS_CTRL    = 4'h8;
    // status word field positions
    localparam int          BIT_C       = 0;
    localparam int          BIT_Z       = 1;
    localparam int          BIT_OV      = 2;
    localparam int          BIT_N       = 3;
    localparam int          BIT_RA      = 4;
    localparam int          BIT_IPL     = 5;
    localparam int          BIT_DC      = 8;
    // core control and config field positions
    localparam int          BIT_EXT     = 3;
    localparam int          BIT_NEST    = 15;
    // reset values
    localparam logic [15:0] RST_STATUS  = 16'h0000;
    localparam logic        RST_EXT     = 1'b0;
    localparam logic        RST_NEST    = 1'b0;
    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_DECERR = 2'b11;

    // datapath operations that touch the flags
    typedef enum logic [2:0] {
        op_add   = 3'b000,
        op_addc  = 3'b001,
        op_sub   = 3'b010,
        op_subb  = 3'b011,
        op_logic = 3'b100
    } csfl_op_e;

    // flag update request from the instruction datapath
    typedef struct packed {
        logic        valid;
        csfl_op_e    op;
        logic        byte_mode;
        logic [15:0] a;
        logic [15:0] b;
    } csfl_req_s;

    // arithmetic result flags
    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } csfl_flags_s;

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] csfl_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  ws);
        logic [15:0] r;
        r = old_v;
        if (ws[0]) begin
            r[7:0] = wd[7:0];
        end
        if (ws[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction
endpackage

// File: testbench/csfl_status_tb_top.sv
// Purpose: self-checking bench for the cpu status word block
// Assumes: bench drives datapath and axi4-lite ports directly, no partner model
// Notes:   expected flags come from a bench-side arithmetic model
`timescale 1ns/100ps
module csfl_status_tb_top
    import csfl_pkg::*;
;
    // clock, reset and datapath stimulus
    logic        sys_clk       = 1'b0;
    logic        sys_rst       = 1'b1;
    csfl_req_s   flag_req      = '0;
    logic        repeat_busy   = 1'b0;
    logic        prio_ext_set  = 1'b0;
    // observed status
    logic [15:0] cpu_status_word;
    logic [3:0]  cpu_priority_level;
    logic        nesting_off_bit;
    // register bus
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [3:0]  s_axi_awaddr  = 4'h0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [3:0]  s_axi_araddr  = 4'h0;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    // bookkeeping
    int          num_errors      = 0;
    int          samples_checked = 0;
    logic [4:0]  fl              = 5'h0; // model flags {dc,n,ov,z,c}

    csfl_status dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .flag_req(flag_req),
        .repeat_busy(repeat_busy), .prio_ext_set(prio_ext_set),
        .cpu_status_word(cpu_status_word), .cpu_priority_level(cpu_priority_level),
        .nesting_off_bit(nesting_off_bit),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
    );

    // 100 mhz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // verdict and end of run
    task automatic test_done();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bench-side flag model; logic ops keep dc, ov and c
    function automatic logic [4:0] mdl(input csfl_op_e op, input logic bm,
                                       input logic [15:0] a, input logic [15:0] b,
                                       input logic [4:0] old);
        logic [16:0] s, h;
        logic [15:0] m, hm, bb, r;
        logic        ci, sa, sb, n, z;
        m  = bm ? 16'h00ff : 16'hffff;
        hm = bm ? 16'h000f : 16'h00ff;
        bb = (op == op_sub || op == op_subb) ? ~b : b;
        ci = (op == op_sub) ? 1'b1 : ((op == op_addc || op == op_subb) ? old[0] : 1'b0);
        s  = {1'b0, a & m} + {1'b0, bb & m} + {16'h0, ci};
        h  = {1'b0, a & hm} + {1'b0, bb & hm} + {16'h0, ci};
        r  = (op == op_logic) ? (a & m) : (s[15:0] & m);
        n  = bm ? r[7] : r[15];
        z  = (r == 16'h0);
        if (op == op_logic) begin
            return {old[4], n, old[2], z, old[0]};
        end
        sa = bm ? a[7] : a[15];
        sb = bm ? bb[7] : bb[15];
        return {bm ? h[4] : h[8], n, (sa == sb) && (n != sa), z, bm ? s[8] : s[16]};
    endfunction

    // one datapath strobe, flags checked the cycle after
    task automatic fire(input csfl_op_e op, input logic bm, input logic [15:0] a,
                        input logic [15:0] b);
        logic [4:0] e;
        e = mdl(op, bm, a, b, fl);
        @(posedge sys_clk);
        flag_req <= '{valid: 1'b1, op: op, byte_mode: bm, a: a, b: b};
        @(posedge sys_clk);
        flag_req.valid <= 1'b0;
        #1;
        chk("flags", {27'h0, e}, {27'h0, cpu_status_word[8], cpu_status_word[3:0]});
        fl = e;
    endtask

    // axi4-lite write, aw and w offered together
    task automatic wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic ga, gw, dn;
        ga = 1'b0;
        gw = 1'b0;
        dn = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!dn) begin
            @(posedge sys_clk);
            if (ga && gw && s_axi_bvalid === 1'b1) begin
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                s_axi_bready <= 1'b0;
                dn = 1'b1;
            end
            if (!ga && s_axi_awready === 1'b1) begin
                ga = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!gw && s_axi_wready === 1'b1) begin
                gw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask

    // axi4-lite read with data and response compare
    task automatic rd(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
        logic ga, dn;
        ga = 1'b0;
        dn = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!dn) begin
            @(posedge sys_clk);
            if (ga && s_axi_rvalid === 1'b1) begin
                chk("rdata", ed, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                s_axi_rready <= 1'b0;
                dn = 1'b1;
            end
            if (!ga && s_axi_arready === 1'b1) begin
                ga = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(OFS_CORE, 32'h0, RESP_OKAY);
        rd(OFS_CTRL, 32'h0, RESP_OKAY);
        // flag table: every op in word mode, add, sub and logic in byte mode, boundary operands
        fire(op_add, 1'b0, 16'h7fff, 16'h0001);
        fire(op_add, 1'b0, 16'hffff, 16'h0001);
        fire(op_addc, 1'b0, 16'h0000, 16'h0000);
        fire(op_add, 1'b1, 16'h120f, 16'h0001);
        fire(op_sub, 1'b0, 16'h0005, 16'h0005);
        fire(op_sub, 1'b0, 16'h0003, 16'h0004);
        fire(op_sub, 1'b1, 16'h0000, 16'h0001);
        fire(op_subb, 1'b0, 16'h8000, 16'h0001);
        fire(op_logic, 1'b0, 16'h8000, 16'h0000);
        fire(op_logic, 1'b1, 16'h0100, 16'h0000);
        fire(op_logic, 1'b0, 16'h0000, 16'h0000);
        // repeat bit follows the loop, software writes ignored
        @(posedge sys_clk);
        repeat_busy <= 1'b1;
        wr(OFS_STATUS, 32'h0, 4'hf, RESP_OKAY);
        rd(OFS_STATUS, 32'h0010, RESP_OKAY);
        @(posedge sys_clk);
        repeat_busy <= 1'b0;
        wr(OFS_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(OFS_STATUS, 32'h01ef, RESP_OKAY);
        wr(OFS_STATUS, 32'h0000_fe00, 4'h2, RESP_OKAY);
        rd(OFS_STATUS, 32'h00ef, RESP_OKAY);
        // priority level with and without the extension bit
        wr(OFS_STATUS, 32'h00c0, 4'h1, RESP_OKAY);
        chk("level", 32'h6, {28'h0, cpu_priority_level});
        @(posedge sys_clk);
        prio_ext_set <= 1'b1;
        @(posedge sys_clk);
        prio_ext_set <= 1'b0;
        wr(OFS_CORE, 32'h0, 4'h0, RESP_OKAY);
        chk("level", 32'he, {28'h0, cpu_priority_level});
        rd(OFS_CORE, 32'h8, RESP_OKAY);
        wr(OFS_CORE, 32'h0, 4'hf, RESP_OKAY);
        chk("level", 32'h6, {28'h0, cpu_priority_level});
        wr(OFS_CORE, 32'h8, 4'hf, RESP_OKAY);
        rd(OFS_CORE, 32'h0, RESP_OKAY);
        // nesting off locks the low priority bits
        wr(OFS_CTRL, 32'h8000, 4'hf, RESP_OKAY);
        chk("nest", 32'h1, {31'h0, nesting_off_bit});
        wr(OFS_STATUS, 32'h0020, 4'h1, RESP_OKAY);
        rd(OFS_STATUS, 32'h00c0, RESP_OKAY);
        wr(OFS_CTRL, 32'h0, 4'hf, RESP_OKAY);
        chk("nest", 32'h0, {31'h0, nesting_off_bit});
        wr(OFS_STATUS, 32'h0020, 4'h1, RESP_OKAY);
        rd(OFS_STATUS, 32'h0020, RESP_OKAY);
        chk("level", 32'h1, {28'h0, cpu_priority_level});
        // unmapped address answers with decode error
        wr(4'hc, 32'h1234_5678, 4'hf, RESP_DECERR);
        rd(4'hc, 32'h0, RESP_DECERR);
        test_done();
    end
endmodule
